// ==== core/flash_guard_pkg.sv ====
`default_nettype none
package flash_guard_pkg;
  // Register byte addresses on the Wishbone bus.
  localparam logic [31:0] ROM_SEC_ADDR = 32'hffffe518;
  localparam logic [31:0] CTRL_STAT_ADDR = 32'hffffe520;
  localparam logic [31:0] IRQ_STAT_ADDR = 32'hffffe528;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'hffffe52c;

  // Control/status field positions.
  localparam int RDY_POS = 0;
  localparam int PRG_POS = 1;
  localparam int KIND_POS = 2;
  localparam int PROT_LSB = 4;
  localparam int PROT_MSB = 7;
  localparam int RSEC_POS = 0;

  // Reset values.
  localparam logic PRG_RST = 1'b0;
  localparam logic RSEC_RST = 1'b1;
  localparam logic [3:0] PROT_RST = 4'h0;
  localparam logic [3:0] IRQ_RST = 4'h0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [3:0] ALL_LANES = 4'hf;

  // Interrupt event bits.
  localparam int EV_DONE = 0;
  localparam int EV_FAIL = 1;
  localparam int EV_REJECT = 2;
  localparam int EV_PROT = 3;
  localparam int EV_COUNT = 4;

  typedef enum logic [2:0] {
    RB_READY = 3'b001,
    RB_BUSY = 3'b010,
    RB_FAIL = 3'b100
  } rb_state_t;

  typedef struct packed {
    rb_state_t st;
    logic program_issue_bit;
    logic rsecon;
    logic locked;
    logic [3:0] prot;
    logic [3:0] irq_st;
    logic [3:0] irq_mask;
    logic ack;
    logic [31:0] rdata;
    logic fwd;
    logic rej;
  } guard_state_t;
endpackage : flash_guard_pkg
`default_nettype wire

// ==== core/flash_status_and_rom_guard.sv ====
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module flash_status_and_rom_guard
  import flash_guard_pkg::*;
#(
  parameter logic ROM_KIND = 1'b0,
  parameter int AREAS = 4
) (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Command path from the CPU toward the array
  input wire logic cmd_req_i,
  input wire logic cmd_is_prog_i,
  input wire logic cmd_is_reset_i,
  input wire logic [1:0] cmd_area_i,
  output logic cmd_fwd_o,
  output logic cmd_reject_o,
  // Automatic operation controller
  input wire logic op_start_i,
  input wire logic op_done_i,
  input wire logic op_fail_i,
  input wire logic [AREAS-1:0] protect_i,
  // Status toward the system
  output logic ready_busy_o,
  output logic rom_secure_o,
  output logic irq_o
);

  guard_state_t q;
  guard_state_t d;

  logic bus_req;
  logic bus_wr;
  logic full_word;
  logic cmd_ok;
  logic prot_hit;
  logic [EV_COUNT-1:0] ev;
  logic [3:0] clr;

  function automatic logic [31:0] ctrl_word(input guard_state_t s, input logic kind);
    logic [31:0] w;
    w = ZERO_WORD;
    w[RDY_POS] = (s.st == RB_READY);
    w[PRG_POS] = s.program_issue_bit;
    w[KIND_POS] = kind;
    w[PROT_MSB:PROT_LSB] = s.prot;
    return w;
  endfunction : ctrl_word

  function automatic logic [31:0] nib_word(input logic [3:0] v);
    logic [31:0] w;
    w = ZERO_WORD;
    w[3:0] = v;
    return w;
  endfunction : nib_word

  // A new request is seen in its first cycle; ack follows one edge later.
  assign bus_req = wb_cyc_i && wb_stb_i && !q.ack;
  // Writes land on the edge at which the master samples ack.
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && q.ack;
  assign full_word = (wb_sel_i == ALL_LANES);

  assign prot_hit = cmd_is_prog_i && q.prot[cmd_area_i];

  always_comb begin
    cmd_ok = 1'b0;
    ev = '0;
    clr = '0;
    d = q;
    d.fwd = 1'b0;
    d.rej = 1'b0;
    d.prot = protect_i[3:0];

    // Read path and acknowledge.
    d.ack = bus_req;
    if (bus_req) begin
      if (wb_adr_i == CTRL_STAT_ADDR) begin
        d.rdata = ctrl_word(q, ROM_KIND);
      end else if (wb_adr_i == ROM_SEC_ADDR) begin
        d.rdata = ZERO_WORD;
        d.rdata[RSEC_POS] = q.rsecon;
      end else if (wb_adr_i == IRQ_STAT_ADDR) begin
        d.rdata = nib_word(q.irq_st);
      end else if (wb_adr_i == IRQ_MASK_ADDR) begin
        d.rdata = nib_word(q.irq_mask);
      end else begin
        // Unmapped addresses still answer, reading zero.
        d.rdata = ZERO_WORD;
      end
    end

    // Write path; the read-only fields simply ignore writes.
    if (bus_wr) begin
      if (wb_adr_i == CTRL_STAT_ADDR) begin
        if (wb_sel_i[0]) begin
          d.program_issue_bit = wb_dat_i[PRG_POS];
        end
      end else if (wb_adr_i == ROM_SEC_ADDR) begin
        // Only whole-word writes are honoured for this register.
        if (full_word) begin
          d.rsecon = wb_dat_i[RSEC_POS];
        end
      end else if (wb_adr_i == IRQ_STAT_ADDR) begin
        if (wb_sel_i[0]) begin
          clr = wb_dat_i[3:0];
        end
      end else if (wb_adr_i == IRQ_MASK_ADDR) begin
        if (wb_sel_i[0]) begin
          d.irq_mask = wb_dat_i[3:0];
        end
      end
    end

    // Command gating.
    if (cmd_req_i) begin
      if (cmd_is_reset_i) begin
        cmd_ok = 1'b1;
        d.locked = 1'b0;
        d.st = RB_READY;
      end else if (q.locked || !q.program_issue_bit) begin
        // Without the issue bit set the interface passes only reset commands.
        ev[EV_REJECT] = 1'b1;
      end else if (q.st != RB_READY) begin
        d.locked = 1'b1;
        ev[EV_REJECT] = 1'b1;
      end else if (prot_hit) begin
        ev[EV_PROT] = 1'b1;
      end else begin
        cmd_ok = 1'b1;
      end
    end
    d.fwd = cmd_ok;
    d.rej = cmd_req_i && !cmd_ok;

    // Ready/busy tracking of the automatic operation.
    if (!(cmd_req_i && cmd_is_reset_i)) begin
      case (q.st)
        RB_READY: begin
          if (op_start_i) begin
            d.st = RB_BUSY;
          end
        end
        RB_BUSY: begin
          if (op_fail_i) begin
            d.st = RB_FAIL;
            ev[EV_FAIL] = 1'b1;
          end else if (op_done_i) begin
            d.st = RB_READY;
            ev[EV_DONE] = 1'b1;
          end
        end
        RB_FAIL: begin
          // Only a reset or a reset command leaves this state.
          d.st = RB_FAIL;
        end
        default: begin
          d.st = RB_READY;
        end
      endcase
    end

    // A new event wins over a clear in the same cycle.
    d.irq_st = (q.irq_st & ~clr) | ev;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      q.st <= RB_READY;
      q.program_issue_bit <= PRG_RST;
      q.rsecon <= RSEC_RST;
      q.locked <= 1'b0;
      q.prot <= PROT_RST;
      q.irq_st <= IRQ_RST;
      q.irq_mask <= IRQ_RST;
      q.ack <= 1'b0;
      q.rdata <= ZERO_WORD;
      q.fwd <= 1'b0;
      q.rej <= 1'b0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign wb_dat_o = q.rdata;
  assign wb_ack_o = q.ack;
  assign cmd_fwd_o = q.fwd;
  assign cmd_reject_o = q.rej;
  assign ready_busy_o = (q.st == RB_READY);
  assign rom_secure_o = q.rsecon;
  assign irq_o = |(q.irq_st & q.irq_mask);

endmodule : flash_status_and_rom_guard
`default_nettype wire

// ==== testbench/op_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module op_ctrl_model (
  // Clock and request
  input wire logic ref_clk,
  input wire logic go,
  input wire logic bad,
  // Operation reports
  output var logic op_start_i = 1'b0,
  output var logic op_done_i = 1'b0,
  output var logic op_fail_i = 1'b0
);
  logic [3:0] cnt_q = 4'h0;
  always_ff @(posedge ref_clk) begin
    op_start_i <= go;
    cnt_q <= go ? 4'hf : cnt_q - 4'(cnt_q != 4'h0);
    op_done_i <= cnt_q == 4'h1 && !bad;
    op_fail_i <= cnt_q == 4'h1 && bad;
  end
endmodule : op_ctrl_model
`default_nettype wire

// ==== testbench/flash_guard_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_guard_asserts #(
  parameter int AREAS = 4
) (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Commands
  input wire logic cmd_req_i,
  input wire logic cmd_is_prog_i,
  input wire logic cmd_is_reset_i,
  input wire logic [1:0] cmd_area_i,
  input wire logic cmd_fwd_o,
  input wire logic cmd_reject_o,
  // Operation
  input wire logic op_start_i,
  input wire logic op_done_i,
  input wire logic op_fail_i,
  input wire logic [AREAS-1:0] protect_i,
  input wire logic ready_busy_o
);
  default clocking @(posedge ref_clk); endclocking
  // A frozen clock enable stalls every answer, so it suspends the checks.
  default disable iff (!nrst || !clk_en);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_cmd_answer: assert property (cmd_req_i |=> cmd_fwd_o ^ cmd_reject_o)
    else $error("command answer wrong");
  a_busy_show: assert property (ready_busy_o && op_start_i && !cmd_req_i |=> !ready_busy_o)
    else $error("busy not shown");
  a_done_ready: assert property (!ready_busy_o && op_done_i && !op_fail_i |=> ready_busy_o)
    else $error("ready not restored");
  a_fail_hold: assert property (!ready_busy_o && op_fail_i && !cmd_req_i |=> !ready_busy_o)
    else $error("ready after failure");
  a_busy_refuse: assert property (cmd_req_i && !cmd_is_reset_i && !ready_busy_o |=> cmd_reject_o)
    else $error("busy command passed");
  a_prot_refuse: assert property (cmd_req_i && cmd_is_prog_i && !cmd_is_reset_i &&
    protect_i[cmd_area_i] |=> cmd_reject_o) else $error("protected write passed");
  c_fail: cover property (op_fail_i);
  c_fwd: cover property (cmd_fwd_o);
  c_lock: cover property (cmd_reject_o && ready_busy_o);
endmodule : flash_guard_asserts
bind flash_status_and_rom_guard flash_guard_asserts #(.AREAS(AREAS)) chk_u (.*);
`default_nettype wire

// ==== testbench/flash_status_and_rom_guard_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_status_and_rom_guard_tb import flash_guard_pkg::*; ;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
  logic ref_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, cmd_req_i = 1'b0, cmd_is_prog_i = 1'b0, cmd_is_reset_i = 1'b0;
  logic bad = 1'b0, wb_ack_o, irq_o, cmd_fwd_o, cmd_reject_o, ready_busy_o, rom_secure_o;
  logic op_start_i, op_done_i, op_fail_i;
  logic [1:0] cmd_area_i = 2'h0, c;
  logic [3:0] pr, protect_i = 4'h0;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, e;
  logic [31:0] rq[$];
  logic [1:0] cq[$];
  int n_errors = 0, n_tests = 0;
  flash_status_and_rom_guard dut_u (.wb_sel_i(ALL_LANES), .*);
  op_ctrl_model pm_u (.go(cmd_fwd_o && !cmd_is_reset_i), .*);
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      e = rq.pop_front();
      `CHK(wb_dat_o, e)
    end
    if (cmd_fwd_o === 1'b1 || cmd_reject_o === 1'b1) begin
      c = cq.pop_front();
      `CHK({cmd_fwd_o, cmd_reject_o}, c)
    end
  end
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, ex);
    if (!w) rq.push_back(ex);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask : wb
  // Expected answer is {forwarded, refused}.
  task automatic cmd(input logic rs, pg, input logic [1:0] ar, ex);
    cq.push_back(ex);
    cmd_is_reset_i <= rs;
    cmd_is_prog_i <= pg;
    cmd_area_i <= ar;
    cmd_req_i <= 1'b1;
    @(posedge ref_clk);
    cmd_req_i <= 1'b0;
    @(posedge ref_clk);
  endtask : cmd
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    #100us;
    n_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'hfbdc));
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    wb(0, CTRL_STAT_ADDR, 0, 32'h1);
    wb(0, ROM_SEC_ADDR, 0, 32'h1);
    `CHK(rom_secure_o, 1'b1)
    wb(0, 32'hffffe500, 0, ZERO_WORD);
    wb(1, ROM_SEC_ADDR, 0, 0);
    wb(0, ROM_SEC_ADDR, 0, ZERO_WORD);
    `CHK(rom_secure_o, 1'b0)
    $display("register test done");
    // Area 0 always protected and area 1 never, so both outcomes are reached.
    pr = {2'($urandom), 2'b01};
    protect_i <= pr;
    wb(1, IRQ_MASK_ADDR, 32'hf, 0);
    cmd(0, 1, 1, 2'b01);
    wb(1, CTRL_STAT_ADDR, 32'h2, 0);
    wb(0, CTRL_STAT_ADDR, 0, {24'h0, pr, 4'h3});
    cmd(0, 1, 0, 2'b01);
    cmd(0, 1, 1, 2'b10);
    repeat (2) @(posedge ref_clk);
    wb(0, CTRL_STAT_ADDR, 0, {24'h0, pr, 4'h2});
    cmd(0, 0, 1, 2'b01);
    repeat (20) @(posedge ref_clk);
    wb(0, CTRL_STAT_ADDR, 0, {24'h0, pr, 4'h3});
    cmd(0, 0, 1, 2'b01);
    cmd(1, 0, 0, 2'b10);
    $display("command test done");
    bad <= 1'b1;
    cmd(0, 0, 2, 2'b10);
    repeat (20) @(posedge ref_clk);
    wb(0, CTRL_STAT_ADDR, 0, {24'h0, pr, 4'h2});
    cmd(1, 0, 0, 2'b10);
    wb(1, CTRL_STAT_ADDR, 0, 0);
    wb(0, CTRL_STAT_ADDR, 0, {24'h0, pr, 4'h1});
    $display("failure test done");
    `CHK(irq_o, 1'b1)
    wb(1, IRQ_MASK_ADDR, 0, 0);
    `CHK(irq_o, 1'b0)
    wb(1, IRQ_MASK_ADDR, 32'hf, 0);
    wb(0, IRQ_STAT_ADDR, 0, 32'hf);
    wb(1, IRQ_STAT_ADDR, 32'hf, 0);
    `CHK(irq_o, 1'b0)
    $display("interrupt test done");
    // A low enable must hold the captured protection bits while the pins move.
    clk_en <= 1'b0;
    protect_i <= ~pr;
    repeat (3) @(posedge ref_clk);
    clk_en <= 1'b1;
    wb(0, CTRL_STAT_ADDR, 0, {24'h0, pr, 4'h1});
    wb(0, CTRL_STAT_ADDR, 0, {24'h0, ~pr, 4'h1});
    $display("enable test done");
    end_of_test();
  end
endmodule : flash_status_and_rom_guard_tb
`default_nettype wire
